// File: hw/lfs_pkg.sv
package lfs_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int LFS_AW = 12;
    localparam int LFS_DW = 32;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] LFS_IDX_SLS_GH  = 8'ha6;
    localparam logic [7:0] LFS_IDX_OPEN_AB = 8'ha7;
    localparam logic [7:0] LFS_IDX_OPEN_CD = 8'ha8;
    localparam logic [7:0] LFS_IDX_IRQ_STS = 8'hb0;
    localparam logic [7:0] LFS_IDX_IRQ_CLR = 8'hb1;
    localparam logic [7:0] LFS_IDX_IRQ_EN  = 8'hb2;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         LFS_HI_LSB     = 4;
    localparam int         LFS_LO_LSB     = 0;
    localparam int         LFS_RSVD_HI    = 7;
    localparam int         LFS_RSVD_LO    = 3;
    localparam logic [7:0] LFS_FLAG_RST   = 8'h00;
    localparam logic [2:0] LFS_IRQ_RST    = 3'h0;
    localparam int         LFS_IRQ_SLS    = 0;
    localparam int         LFS_IRQ_OPENAB = 1;
    localparam int         LFS_IRQ_OPENCD = 2;

    // Six channel levels: [5:3] upper group ch2..0, [2:0] lower ch2..0
    typedef logic [5:0] lfs_pair_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [LFS_AW-1:0] paddr;
        logic [LFS_DW-1:0] pwdata;
    } lfs_apb_req_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [LFS_AW-1:0] lfs_addr(input logic [7:0] idx);
        lfs_addr = {2'h0, idx, 2'h0};
    endfunction : lfs_addr

    // Reserved bits 7 and 3 are forced low here
    function automatic logic [7:0] lfs_pack(input lfs_pair_t f);
        lfs_pack = 8'h00;
        lfs_pack[LFS_HI_LSB +: 3] = f[5:3];
        lfs_pack[LFS_LO_LSB +: 3] = f[2:0];
    endfunction : lfs_pack

endpackage : lfs_pkg

// File: hw/lfs_flag_byte.sv
`timescale 1ns/10ps

module lfs_flag_byte
    import lfs_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Detector levels
    input  wire lfs_pair_t  fault_i,
    // Status byte and new-fault pulse
    output logic [7:0]      flags_o,
    output logic            rise_o
);

    typedef struct packed {
        logic [7:0] flags;
        logic       rise;
    } lfs_fb_state_t;

    lfs_fb_state_t s_q;
    lfs_fb_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (ce_i)
        begin
            s_d.flags = lfs_pack(fault_i);
            s_d.rise  = |(s_d.flags & ~s_q.flags);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q.flags <= LFS_FLAG_RST;
            s_q.rise  <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign flags_o = s_q.flags;
    assign rise_o  = s_q.rise;

endmodule : lfs_flag_byte

// File: hw/lfs_status_bank.sv
`timescale 1ns/10ps

module lfs_status_bank
    import lfs_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // APB slave
    input  wire lfs_apb_req_t      apb_i,
    output logic [LFS_DW-1:0]      prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Fault detector levels
    input  wire lfs_pair_t         sls_fault_gh_i,
    input  wire lfs_pair_t         open_fault_ab_i,
    input  wire lfs_pair_t         open_fault_cd_i,
    // Interrupt
    output logic                   irq_o
);

    // ------------------------------------------------------------
    // Flag bytes
    // ------------------------------------------------------------
    logic [7:0] sls_flags_gh;
    logic [7:0] open_flags_ab;
    logic [7:0] open_flags_cd;
    logic [2:0] flag_rise;

    lfs_flag_byte u_sls_gh (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .fault_i (sls_fault_gh_i),
        .flags_o (sls_flags_gh),
        .rise_o  (flag_rise[LFS_IRQ_SLS])
    );

    lfs_flag_byte u_open_ab (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .fault_i (open_fault_ab_i),
        .flags_o (open_flags_ab),
        .rise_o  (flag_rise[LFS_IRQ_OPENAB])
    );

    lfs_flag_byte u_open_cd (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .fault_i (open_fault_cd_i),
        .flags_o (open_flags_cd),
        .rise_o  (flag_rise[LFS_IRQ_OPENCD])
    );

    // ------------------------------------------------------------
    // Bus and interrupt state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LFS_DW-1:0] prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
        logic [2:0]        sts;
        logic [2:0]        en;
    } lfs_state_t;

    lfs_state_t s_q;
    lfs_state_t s_d;

    logic       access;
    logic [2:0] clr_mask;

    // One wait state: pready is raised on the second access cycle
    assign access = apb_i.psel && apb_i.penable && !s_q.pready;

    always_comb
    begin
        s_d      = s_q;
        clr_mask = 3'h0;
        if (ce_i)
        begin
            s_d.pready  = access;
            s_d.pslverr = 1'b0;
            if (access)
            begin
                s_d.prdata = '0;
                if (apb_i.paddr == lfs_addr(LFS_IDX_SLS_GH))
                begin
                    if (!apb_i.pwrite)
                        s_d.prdata[7:0] = sls_flags_gh;
                end
                else if (apb_i.paddr == lfs_addr(LFS_IDX_OPEN_AB))
                begin
                    if (!apb_i.pwrite)
                        s_d.prdata[7:0] = open_flags_ab;
                end
                else if (apb_i.paddr == lfs_addr(LFS_IDX_OPEN_CD))
                begin
                    if (!apb_i.pwrite)
                        s_d.prdata[7:0] = open_flags_cd;
                end
                else if (apb_i.paddr == lfs_addr(LFS_IDX_IRQ_STS))
                begin
                    if (!apb_i.pwrite)
                        s_d.prdata[2:0] = s_q.sts;
                end
                else if (apb_i.paddr == lfs_addr(LFS_IDX_IRQ_CLR))
                begin
                    if (apb_i.pwrite)
                        clr_mask = apb_i.pwdata[2:0];
                end
                else if (apb_i.paddr == lfs_addr(LFS_IDX_IRQ_EN))
                begin
                    if (apb_i.pwrite)
                        s_d.en = apb_i.pwdata[2:0];
                    else
                        s_d.prdata[2:0] = s_q.en;
                end
                else
                begin
                    s_d.pslverr = 1'b1;
                end
            end
            // New fault wins over a clear in the same cycle
            s_d.sts = (s_q.sts & ~clr_mask) | flag_rise;
            s_d.irq = |(s_d.sts & s_d.en);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_q.prdata  <= '0;
            s_q.pready  <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.irq     <= 1'b0;
            s_q.sts     <= LFS_IRQ_RST;
            s_q.en      <= LFS_IRQ_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata_o  = s_q.prdata;
    assign pready_o  = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign irq_o     = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic rd_done;
    logic wr_done;

    // Master holds the request through the pready edge
    assign rd_done = pready_o && apb_i.psel && apb_i.penable
                     && !apb_i.pwrite;
    assign wr_done = pready_o && apb_i.psel && apb_i.penable
                     && apb_i.pwrite;

    property p_sls_read;
        @(posedge clk_i) disable iff (rst_i)
        rd_done && apb_i.paddr == lfs_addr(LFS_IDX_SLS_GH)
        |-> prdata_o == {24'h0, lfs_pack($past(sls_fault_gh_i, 2))}
            || !$past(ce_i) || !$past(ce_i, 2);
    endproperty
    a_sls_read: assert property (p_sls_read)
        else $error("short byte read has wrong layout");

    property p_open_ab_read;
        @(posedge clk_i) disable iff (rst_i)
        rd_done && apb_i.paddr == lfs_addr(LFS_IDX_OPEN_AB)
        |-> prdata_o[7:0] == $past(open_flags_ab) && prdata_o[31:8] == '0;
    endproperty
    a_open_ab_read: assert property (p_open_ab_read)
        else $error("open byte AB read mismatch");

    property p_open_cd_read;
        @(posedge clk_i) disable iff (rst_i)
        rd_done && apb_i.paddr == lfs_addr(LFS_IDX_OPEN_CD)
        |-> prdata_o == {24'h0, $past(open_flags_cd)};
    endproperty
    a_open_cd_read: assert property (p_open_cd_read)
        else $error("open byte CD read mismatch");

    property p_open_follow;
        @(posedge clk_i) disable iff (rst_i)
        ce_i ##1 1'b1
        |-> open_flags_ab == lfs_pack($past(open_fault_ab_i))
            && open_flags_cd == lfs_pack($past(open_fault_cd_i));
    endproperty
    a_open_follow: assert property (p_open_follow)
        else $error("open flag does not follow detector");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        !open_flags_ab[LFS_RSVD_HI] && !open_flags_ab[LFS_RSVD_LO]
        && !open_flags_cd[LFS_RSVD_HI] && !open_flags_cd[LFS_RSVD_LO]
        && !sls_flags_gh[LFS_RSVD_HI] && !sls_flags_gh[LFS_RSVD_LO];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved flag bit set");

    property p_reset_zero;
        @(posedge clk_i)
        $past(rst_i) && !rst_i
        |-> sls_flags_gh == LFS_FLAG_RST && open_flags_ab == LFS_FLAG_RST
            && open_flags_cd == LFS_FLAG_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("flag byte not zero after reset");

    property p_write_ignored;
        @(posedge clk_i) disable iff (rst_i)
        wr_done && ce_i && apb_i.paddr == lfs_addr(LFS_IDX_OPEN_AB)
        |-> !pslverr_o && prdata_o == '0
            ##1 open_flags_ab == lfs_pack($past(open_fault_ab_i));
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write reached a flag byte");

    property p_irq_level;
        @(posedge clk_i) disable iff (rst_i)
        irq_o == |(s_q.sts & s_q.en);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level does not match status");

    property p_pready_pulse;
        @(posedge clk_i) disable iff (rst_i)
        pready_o && ce_i |=> !pready_o;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("pready held longer than one cycle");

    property p_write_ignored_sls;
        @(posedge clk_i) disable iff (rst_i)
        wr_done && ce_i && apb_i.paddr == lfs_addr(LFS_IDX_SLS_GH)
        |-> !pslverr_o && prdata_o == '0
            ##1 sls_flags_gh == lfs_pack($past(sls_fault_gh_i));
    endproperty
    a_write_ignored_sls: assert property (p_write_ignored_sls)
        else $error("write reached the short byte");

    property p_write_ignored_cd;
        @(posedge clk_i) disable iff (rst_i)
        wr_done && ce_i && apb_i.paddr == lfs_addr(LFS_IDX_OPEN_CD)
        |-> !pslverr_o && prdata_o == '0
            ##1 open_flags_cd == lfs_pack($past(open_fault_cd_i));
    endproperty
    a_write_ignored_cd: assert property (p_write_ignored_cd)
        else $error("write reached open byte CD");

    // Only a taken clear write may drop a status bit
    property p_sts_sticky;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !(access && apb_i.pwrite
                  && apb_i.paddr == lfs_addr(LFS_IDX_IRQ_CLR))
        |=> (s_q.sts & $past(s_q.sts)) == $past(s_q.sts);
    endproperty
    a_sts_sticky: assert property (p_sts_sticky)
        else $error("status bit lost without a clear");

    property p_sts_set;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && |flag_rise
        |=> (s_q.sts & $past(flag_rise)) == $past(flag_rise);
    endproperty
    a_sts_set: assert property (p_sts_set)
        else $error("new fault did not set status");

    // Flag bytes never answer with an error
    property p_err_unmapped;
        @(posedge clk_i) disable iff (rst_i)
        pready_o && pslverr_o
        |-> prdata_o == '0
            && apb_i.paddr != lfs_addr(LFS_IDX_SLS_GH)
            && apb_i.paddr != lfs_addr(LFS_IDX_OPEN_AB)
            && apb_i.paddr != lfs_addr(LFS_IDX_OPEN_CD);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("error answer on a flag byte");

    // Clock enable low must freeze bus, interrupt and open flag state
    property p_ce_freeze;
        @(posedge clk_i) disable iff (rst_i)
        !ce_i
        |=> s_q == $past(s_q) && open_flags_cd == $past(open_flags_cd)
            && open_flags_ab == $past(open_flags_ab);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved while clock enable low");

endmodule : lfs_status_bank

// File: sim/test_lfs_status_bank.sv
`timescale 1ns/10ps

module test_lfs_status_bank
    import lfs_pkg::*;
;
    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    logic              clk_i     = 1'b0;
    logic              rst_i     = 1'b1;
    logic              ce_i      = 1'b1;
    lfs_apb_req_t      apb_i     = '0;
    lfs_pair_t         det [3]   = '{default: '0};
    logic [LFS_DW-1:0] prdata_o;
    logic              pready_o;
    logic              pslverr_o;
    logic              irq_o;
    logic [31:0]       rd;
    logic              err;
    lfs_pair_t         f;
    int                n_errors  = 0;
    int                cmp_count = 0;
    int                cyc       = 0;
    logic [7:0]        fidx [3]  = '{LFS_IDX_SLS_GH, LFS_IDX_OPEN_AB,
                                     LFS_IDX_OPEN_CD};

    always #10 clk_i = ~clk_i;

    lfs_status_bank dut (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .ce_i            (ce_i),
        .apb_i           (apb_i),
        .prdata_o        (prdata_o),
        .pready_o        (pready_o),
        .pslverr_o       (pslverr_o),
        .sls_fault_gh_i  (det[0]),
        .open_fault_ab_i (det[1]),
        .open_fault_cd_i (det[2]),
        .irq_o           (irq_o)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Reserved bits 7 and 3 always low
    function automatic logic [31:0] pk(input lfs_pair_t v);
        pk = {24'h0, 1'b0, v[5:3], 1'b0, v[2:0]};
    endfunction : pk

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge clk_i);
        apb_i <= '{1'b1, 1'b0, wr, {2'h0, idx, 2'h0}, wd};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        do
            @(posedge clk_i);
        while (pready_o !== 1'b1);
        rd  = prdata_o;
        err = pslverr_o;
        apb_i <= '0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0);
    endtask : rd_chk

    task automatic set_det(input int r, input lfs_pair_t v);
        @(posedge clk_i);
        for (int k = 0; k < 3; k++)
            det[k] <= (k == r) ? v : 6'h00;
    endtask : set_det

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk({31'h0, irq_o}, {31'h0, exp});
    endtask : irq_chk

    // ------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int r = 0; r < 3; r++)
            rd_chk(fidx[r], 32'h0);
        rd_chk(LFS_IDX_IRQ_STS, 32'h0);
        rd_chk(LFS_IDX_IRQ_EN, 32'h0);
        $display("test reset done");
        // Single bits, then all ones to expose reserved bits
        for (int r = 0; r < 3; r++)
            for (int b = 0; b < 7; b++)
            begin
                f = (b == 6) ? 6'h3f : 6'(1 << b);
                set_det(r, f);
                rd_chk(fidx[r], pk(f));
                rd_chk(fidx[(r + 1) % 3], 32'h0);
                apb(1'b1, fidx[r], 32'hffff_ffff);
                chk({31'h0, err}, 32'h0);
                rd_chk(fidx[r], pk(f));
            end
        set_det(0, 6'h00);
        rd_chk(LFS_IDX_SLS_GH, 32'h0);
        $display("test flag map done");
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h11, 32'hffff_ffff);
        chk({31'h0, err}, 32'h1);
        $display("test unmapped done");
        // Interrupt: clear history, enable, raise, mask, clear
        apb(1'b1, LFS_IDX_IRQ_CLR, 32'h7);
        rd_chk(LFS_IDX_IRQ_STS, 32'h0);
        irq_chk(1'b0);
        apb(1'b1, LFS_IDX_IRQ_EN, 32'h7);
        rd_chk(LFS_IDX_IRQ_EN, 32'h7);
        set_det(2, 6'h01);
        irq_chk(1'b1);
        rd_chk(LFS_IDX_OPEN_CD, 32'h1);
        set_det(2, 6'h00);
        rd_chk(LFS_IDX_IRQ_STS, 32'h4);
        apb(1'b1, LFS_IDX_IRQ_EN, 32'h3);
        irq_chk(1'b0);
        apb(1'b1, LFS_IDX_IRQ_EN, 32'h7);
        irq_chk(1'b1);
        apb(1'b1, LFS_IDX_IRQ_CLR, 32'h4);
        irq_chk(1'b0);
        rd_chk(LFS_IDX_IRQ_STS, 32'h0);
        rd_chk(LFS_IDX_IRQ_CLR, 32'h0);
        rd_chk(LFS_IDX_OPEN_CD, 32'h0);
        $display("test interrupt done");
        // Reset in mid-run with a live fault: enable cleared, flag back
        set_det(2, 6'h3f);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(LFS_IDX_IRQ_EN, 32'h0);
        rd_chk(LFS_IDX_IRQ_STS, 32'h4);
        rd_chk(LFS_IDX_OPEN_CD, pk(6'h3f));
        set_det(2, 6'h00);
        $display("test mid reset done");
        // Clock enable low: a fault seen meanwhile leaves no trace
        @(posedge clk_i);
        ce_i <= 1'b0;
        set_det(1, 6'h3f);
        repeat (4) @(posedge clk_i);
        set_det(1, 6'h00);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd_chk(LFS_IDX_OPEN_AB, 32'h0);
        rd_chk(LFS_IDX_IRQ_STS, 32'h4);
        $display("test clock enable done");
        report_and_stop();
    end

endmodule : test_lfs_status_bank
